/* design/lscpd_pkg.sv */
// Purpose: constants and carriers for the link status / channel shutdown bank
// Assumes: axi4-lite slave, 32-bit data, one register per 32-bit word
// Notes: printed offsets are not all multiples of four, so they are indices
package lscpd_pkg;
  // register indices as printed, byte address is four times the index
  localparam logic [11:0] LSCPD_IDX_STATUS = 12'h208;
  localparam logic [11:0] LSCPD_IDX_SHUTDN = 12'h209;
  localparam logic [11:0] LSCPD_IDX_IRQ_ST = 12'h20c;
  localparam logic [11:0] LSCPD_IDX_IRQ_CL = 12'h20d;
  localparam logic [11:0] LSCPD_IDX_IRQ_EN = 12'h20e;
  // status field positions
  localparam int LSCPD_BIT_LINK_UP = 6;
  localparam int LSCPD_BIT_SYNC = 5;
  localparam int LSCPD_BIT_SHIFTED = 4;
  localparam int LSCPD_BIT_ESTAB = 3;
  localparam int LSCPD_BIT_LOCK = 2;
  // control field positions
  localparam int LSCPD_BIT_CHB = 1;
  localparam int LSCPD_BIT_CHA = 0;
  // reset values
  localparam logic [7:0] LSCPD_SHUTDN_RST = 8'h00;
  localparam logic [1:0] LSCPD_FLAGS_RST = 2'h0;
  localparam logic [2:0] LSCPD_IRQ_RST = 3'h0;
  // interrupt event bits: 0 shifted, 1 established, 2 link lost
  localparam int LSCPD_NEV = 3;
  localparam logic [1:0] LSCPD_RESP_OKAY = 2'h0;
  localparam logic [1:0] LSCPD_RESP_SLVERR = 2'h2;

  // raw inputs from the link side, sampled through two flops
  typedef struct packed {
    logic link_up;
    logic sync_n;
    logic sysref_shift;
    logic sysref_event;
    logic pll_lock;
    logic link_transmit_enable;
  } lscpd_link_s;

  // power-down commands toward the datapath
  typedef struct packed {
    logic chan_a_shutdown;
    logic chan_b_shutdown;
    logic lanes_a_off;
    logic lanes_b_off;
    logic subsystem_off;
  } lscpd_pwr_s;
endpackage

/* design/lscpd_top.sv */
// Purpose: status register and channel shutdown control of a two-channel link
// Assumes: one clock aclk at 10 MHz, synchronous active-low reset
// Notes: link-side inputs are asynchronous and pass two flops
// Behaviour
// RL1 - status bit 6 reads high while the link is up
// RL2 - status bit 5 returns live sync request, 0 asserted, 1 released
// RL3 - sticky bit 4 sets whenever sysref shifts an internal clock phase
// RL4 - sticky bit 3 sets once sysref establishes the multiframe clock phase
// RL5 - first sysref after encoder enable sets bit 3, later ones only bit 4
// RL6 - writing one to bit 3 or bit 4 clears that flag
// RL7 - status bit 2 follows serializer pll lock
// RL8 - control bit 1 powers down channel b and its lanes
// RL9 - control bit 0 powers down channel a and its lanes
// RL10 - host clears transmit enable before changing shutdown bits
// RL11 - host uses operating mode, not both bits, to stop both channels
// RL12 - both channels down powers down whole link subsystem, pll, lmfc
// RL13 - shared link a keeps running with channel b off, b slots undefined
// RL14 - writing zero to sticky flags or writing read-only bits does nothing
`timescale 1ns/1ns
module lscpd_top
  import lscpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire lscpd_link_s link_in,
  input wire logic ab_shared_on_link_a,
  output lscpd_pwr_s pwr_r,
  output logic irq_r
);

  // two-flop synchroniser for link-side inputs
  lscpd_link_s sync1_r;
  lscpd_link_s sync2_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= link_in;
      sync2_r <= sync1_r;
    end
  end

  // edge history, read from the second flop only
  logic sysref_d_r;
  logic shift_d_r;
  logic link_d_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sysref_d_r <= 1'b0;
      shift_d_r <= 1'b0;
      link_d_r <= 1'b0;
    end
    else
    begin
      sysref_d_r <= sync2_r.sysref_event;
      shift_d_r <= sync2_r.sysref_shift;
      link_d_r <= sync2_r.link_up;
    end
  end

  logic sysref_rise;
  logic shift_rise;
  logic link_fall;
  assign sysref_rise = sync2_r.sysref_event & ~sysref_d_r;
  assign shift_rise = sync2_r.sysref_shift & ~shift_d_r;
  assign link_fall = link_d_r & ~sync2_r.link_up;

  // axi write side: address and data latched independently
  logic aw_held_r;
  logic w_held_r;
  logic [13:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_go;
  assign wr_go = aw_held_r & w_held_r & ~s_axi_bvalid;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r <= 1'b0;
      awaddr_r <= 14'h0000;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_held_r <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
    else if (wr_go)
      w_held_r <= 1'b0;
  end

  // ready only while the holding slot is empty
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= ~aw_held_r & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_held_r & ~(s_axi_wvalid & s_axi_wready);
    end
  end

  // decode the write; only byte lane 0 carries register data
  logic [11:0] wr_idx;
  logic wr_lane0;
  logic wr_stat;
  logic wr_shut;
  logic wr_clr;
  logic wr_en;
  logic wr_ok;
  assign wr_idx = awaddr_r[13:2];
  assign wr_lane0 = wr_go & wstrb_r[0];
  assign wr_stat = wr_lane0 && wr_idx == LSCPD_IDX_STATUS;
  assign wr_shut = wr_lane0 && wr_idx == LSCPD_IDX_SHUTDN;
  assign wr_clr = wr_lane0 && wr_idx == LSCPD_IDX_IRQ_CL;
  assign wr_en = wr_lane0 && wr_idx == LSCPD_IDX_IRQ_EN;
  assign wr_ok = wr_idx == LSCPD_IDX_STATUS || wr_idx == LSCPD_IDX_SHUTDN
    || wr_idx == LSCPD_IDX_IRQ_ST || wr_idx == LSCPD_IDX_IRQ_CL
    || wr_idx == LSCPD_IDX_IRQ_EN;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= LSCPD_RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? LSCPD_RESP_OKAY : LSCPD_RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // channel shutdown control, reserved bits kept as plain storage
  logic [7:0] shutdn_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      shutdn_r <= LSCPD_SHUTDN_RST;
    else if (wr_shut)
      shutdn_r <= wdata_r[7:0];
  end

  // encoder-enable tracking: arms the first-sysref capture
  logic armed_r;
  logic en_d_r;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      armed_r <= 1'b0;
      en_d_r <= 1'b0;
    end
    else
    begin
      en_d_r <= sync2_r.link_transmit_enable;
      // RL5 first sysref only
      if (!sync2_r.link_transmit_enable)
        armed_r <= 1'b0;
      else if (!en_d_r)
        armed_r <= 1'b1;
      else if (sysref_rise)
        armed_r <= 1'b0;
    end
  end

  // sticky flags: [1] phase shifted, [0] frame clock established
  logic [1:0] flags_r;
  logic set_estab;
  logic set_shift;
  assign set_estab = armed_r & sysref_rise;
  assign set_shift = shift_rise;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= LSCPD_FLAGS_RST;
    else
    begin
      // RL3 set on phase shift, set beats clear
      if (set_shift)
        flags_r[1] <= 1'b1;
      // RL6 write one clears
      // RL14 zero leaves flag alone
      else if (wr_stat && wdata_r[LSCPD_BIT_SHIFTED])
        flags_r[1] <= 1'b0;
      // RL4 set on establishment
      if (set_estab)
        flags_r[0] <= 1'b1;
      // RL6 write one clears
      else if (wr_stat && wdata_r[LSCPD_BIT_ESTAB])
        flags_r[0] <= 1'b0;
    end
  end

  // assembled status byte; read-only bits ignore writes
  logic [7:0] status;
  always_comb
  begin
    status = 8'h00;
    // RL1 link up
    status[LSCPD_BIT_LINK_UP] = sync2_r.link_up;
    // RL2 live sync level
    status[LSCPD_BIT_SYNC] = sync2_r.sync_n;
    status[LSCPD_BIT_SHIFTED] = flags_r[1];
    status[LSCPD_BIT_ESTAB] = flags_r[0];
    // RL7 pll lock
    status[LSCPD_BIT_LOCK] = sync2_r.pll_lock;
  end

  // interrupt status, enable and write-one clear; set beats clear
  logic [LSCPD_NEV-1:0] ev;
  logic [LSCPD_NEV-1:0] irq_st_r;
  logic [LSCPD_NEV-1:0] irq_en_r;
  assign ev = {link_fall, set_estab, set_shift};
  genvar gi;
  generate
    for (gi = 0; gi < LSCPD_NEV; gi++)
    begin : g_irq
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          irq_st_r[gi] <= 1'b0;
        else if (ev[gi])
          irq_st_r[gi] <= 1'b1;
        else if (wr_clr && wdata_r[gi])
          irq_st_r[gi] <= 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_en_r <= LSCPD_IRQ_RST;
    else if (wr_en)
      irq_en_r <= wdata_r[LSCPD_NEV-1:0];
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_r <= 1'b0;
    else
      irq_r <= |(irq_st_r & irq_en_r);
  end

  // power-down outputs toward the datapath
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwr_r <= '0;
    else
    begin
      // RL9 channel a and lanes
      pwr_r.chan_a_shutdown <= shutdn_r[LSCPD_BIT_CHA];
      pwr_r.lanes_a_off <= shutdn_r[LSCPD_BIT_CHA];
      // RL8 channel b and its lanes
      pwr_r.chan_b_shutdown <= shutdn_r[LSCPD_BIT_CHB];
      // RL13 shared link a stays up
      pwr_r.lanes_b_off <= shutdn_r[LSCPD_BIT_CHB] & ~ab_shared_on_link_a;
      // RL12 both down kills subsystem
      pwr_r.subsystem_off <= shutdn_r[LSCPD_BIT_CHA] & shutdn_r[LSCPD_BIT_CHB];
    end
  end

  // read channel: one read at a time, answer one cycle after accept
  logic [11:0] rd_idx;
  assign rd_idx = s_axi_araddr[13:2];
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_axi_arready <= 1'b0;
    else
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= LSCPD_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= LSCPD_RESP_OKAY;
      case (rd_idx)
        LSCPD_IDX_STATUS: s_axi_rdata <= {24'h000000, status};
        LSCPD_IDX_SHUTDN: s_axi_rdata <= {24'h000000, shutdn_r};
        LSCPD_IDX_IRQ_ST: s_axi_rdata <= {29'h00000000, irq_st_r};
        LSCPD_IDX_IRQ_CL: s_axi_rdata <= 32'h00000000;
        LSCPD_IDX_IRQ_EN: s_axi_rdata <= {29'h00000000, irq_en_r};
        default:
        begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= LSCPD_RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

/* verif/lscpd_properties.sv */
// Purpose: port checks for lscpd_top
// Assumes: one clock, sync active-low reset
// Notes: bound to every lscpd_top
`timescale 1ns/1ns
module lscpd_properties
  import lscpd_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ab_shared_on_link_a,
  input wire lscpd_pwr_s pwr_r
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_lanes_a_tie: assert property (pwr_r.lanes_a_off == pwr_r.chan_a_shutdown)
    else $error("lanes a off differs from channel a");
  chk_lanes_b_off: assert property (!pwr_r.chan_b_shutdown |-> !pwr_r.lanes_b_off)
    else $error("lanes b off while channel b on");
  chk_subsys_both: assert property (pwr_r.subsystem_off == (&pwr_r[4:3]))
    else $error("subsystem off not both channels");
  // a mode change may move lanes b on its own, shared link a stays up
  chk_pwr_cause: assert property ($changed(pwr_r) |-> $past(s_axi_bvalid)
    || $past(ab_shared_on_link_a) != $past(ab_shared_on_link_a, 2))
    else $error("power changed without a write");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_rd_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read answer");
endmodule
bind lscpd_top lscpd_properties i_lscpd_properties (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .ab_shared_on_link_a(ab_shared_on_link_a), .pwr_r(pwr_r));

/* verif/lscpd_link_model.sv */
// Purpose: link-side receiver and clock logic stand-in
// Assumes: levels change just after aclk edges
// Notes: pulses held 4 cycles to pass the two-flop sync
`timescale 1ns/1ns
module lscpd_link_model
  import lscpd_pkg::*;
(
  input wire logic aclk,
  output lscpd_link_s link_in
);
  initial link_in = '0;
  // one sysref, optionally with a phase shift
  task automatic sysref(input logic shift);
    @(posedge aclk);
    link_in.sysref_event <= 1'b1;
    link_in.sysref_shift <= shift;
    repeat (4) @(posedge aclk);
    link_in.sysref_event <= 1'b0;
    link_in.sysref_shift <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  // static levels; enable comes from the host side
  task automatic levels(input logic up, sync_n, lock, en);
    @(posedge aclk);
    link_in.link_up <= up;
    link_in.sync_n <= sync_n;
    link_in.pll_lock <= lock;
    link_in.link_transmit_enable <= en;
    repeat (4) @(posedge aclk);
  endtask
endmodule

/* verif/link_status_channel_powerdown_bench.sv */
// Purpose: self-checking bench for lscpd_top
// Assumes: 10 MHz aclk, axi4-lite master tasks
// Notes: seed fixed, one write drops byte lane 0 on purpose
`timescale 1ns/1ns
module link_status_channel_powerdown_bench;
  import lscpd_pkg::*;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, sh = 0;
  logic awr, wrd, bv, arr, rv, irq_r, u, s, k;
  logic [13:0] aw = '0, ar = '0;
  logic [31:0] wd = '0, rdat, v;
  logic [3:0] ws = 4'hf;
  logic [1:0] pd;
  logic [1:0] br, rr, r;
  lscpd_link_s link_in;
  lscpd_pwr_s pwr_r;
  int error_cnt = 0, checks = 0, i;
  lscpd_top i_lscpd_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ar), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .link_in(link_in),
    .ab_shared_on_link_a(sh), .pwr_r(pwr_r), .irq_r(irq_r));
  lscpd_link_model i_lscpd_link_model (.aclk(aclk), .link_in(link_in));
  initial forever #50 aclk = ~aclk;
  task automatic check(input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] exp_st(input logic up, sy, f4, f3, lk);
    return {25'h0, up, sy, f4, f3, lk, 2'h0};
  endfunction
  function automatic logic [31:0] exp_pwr(input logic [1:0] c, input logic shr);
    return {27'h0, c[0], c[1], c[0], c[1] & !shr, &c};
  endfunction
  // byte address is four times the index
  task automatic wr(input logic [11:0] idx, input logic [7:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    aw <= {idx, 2'h0};
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    while (awv && !awr || wv && !wrd);
    // late bready exercises response hold
    repeat ($urandom_range(2)) @(posedge aclk);
    bry <= 1'b1;
    do @(posedge aclk); while (!bv);
    rsp = br;
    bry <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] d, output logic [1:0] rsp);
    @(posedge aclk);
    ar <= {idx, 2'h0};
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rry <= 1'b1;
    do @(posedge aclk); while (!rv);
    d = rdat;
    rsp = rr;
    rry <= 1'b0;
  endtask
  task automatic complete_run();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, tests need a few hundred cycles
  initial
  begin
    #4000000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    void'($urandom(34312));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(LSCPD_IDX_SHUTDN, v, r);
    check(v, 32'h0);
    rd(LSCPD_IDX_STATUS, v, r);
    check(v & 32'h18, 32'h0);
    $display("test reset done");
    for (i = 0; i < 6; i++)
    begin
      {u, s, k} = 3'($urandom);
      i_lscpd_link_model.levels(u, s, k, 1'b0);
      rd(LSCPD_IDX_STATUS, v, r);
      check(v, exp_st(u, s, 1'b0, 1'b0, k));
    end
    $display("test live status done");
    i_lscpd_link_model.levels(1'b1, 1'b1, 1'b1, 1'b0);
    i_lscpd_link_model.sysref(1'b0);
    rd(LSCPD_IDX_STATUS, v, r);
    check(v, exp_st(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
    i_lscpd_link_model.levels(1'b1, 1'b1, 1'b1, 1'b1);
    wr(LSCPD_IDX_IRQ_EN, 8'h01, r);
    i_lscpd_link_model.sysref(1'b0);
    rd(LSCPD_IDX_STATUS, v, r);
    check(v, exp_st(1'b1, 1'b1, 1'b0, 1'b1, 1'b1));
    wr(LSCPD_IDX_STATUS, 8'h08, r);
    i_lscpd_link_model.sysref(1'b1);
    rd(LSCPD_IDX_STATUS, v, r);
    check(v, exp_st(1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
    check({31'h0, irq_r}, 32'h1);
    wr(LSCPD_IDX_STATUS, 8'he7, r);
    rd(LSCPD_IDX_STATUS, v, r);
    check(v, exp_st(1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
    wr(LSCPD_IDX_STATUS, 8'h10, r);
    wr(LSCPD_IDX_IRQ_CL, 8'h01, r);
    repeat (2) @(posedge aclk);
    check({31'h0, irq_r}, 32'h0);
    rd(LSCPD_IDX_STATUS, v, r);
    check(v, exp_st(1'b1, 1'b1, 1'b0, 1'b0, 1'b1));
    // masked event still latches in irq status
    wr(LSCPD_IDX_IRQ_EN, 8'h00, r);
    i_lscpd_link_model.sysref(1'b1);
    check({31'h0, irq_r}, 32'h0);
    rd(LSCPD_IDX_IRQ_ST, v, r);
    check(v & 32'h3, 32'h3);
    // link lost raises the enabled interrupt, irq_r one edge late
    wr(LSCPD_IDX_IRQ_CL, 8'h07, r);
    wr(LSCPD_IDX_IRQ_EN, 8'h04, r);
    i_lscpd_link_model.levels(1'b0, 1'b1, 1'b1, 1'b0);
    repeat (2) @(posedge aclk);
    check({31'h0, irq_r}, 32'h1);
    rd(LSCPD_IDX_IRQ_ST, v, r);
    check(v, 32'h4);
    wr(12'h300, 8'h55, r);
    check({30'h0, r}, {30'h0, LSCPD_RESP_SLVERR});
    rd(12'h300, v, r);
    check({r, v[29:0]}, {LSCPD_RESP_SLVERR, 30'h0});
    $display("test flags done");
    for (i = 0; i < 8; i++)
    begin
      sh <= 1'($urandom);
      // both bits only in the last pass, the one corner case
      pd = (i == 7) ? 2'h3 : (i < 2) ? 2'(i + 1) : 2'($urandom_range(2));
      i_lscpd_link_model.levels(1'b1, 1'b1, 1'b1, 1'b0);
      wr(LSCPD_IDX_SHUTDN, {6'h0, pd}, r);
      check({30'h0, r}, {30'h0, LSCPD_RESP_OKAY});
      repeat (2) @(posedge aclk);
      check({27'h0, pwr_r}, exp_pwr(pd, sh));
      rd(LSCPD_IDX_SHUTDN, v, r);
      check({r, v[29:0]}, {LSCPD_RESP_OKAY, 28'h0, pd});
    end
    // byte lane 0 strobe low: the write must not land
    ws <= 4'he;
    wr(LSCPD_IDX_SHUTDN, 8'h00, r);
    ws <= 4'hf;
    rd(LSCPD_IDX_SHUTDN, v, r);
    check(v, 32'h3);
    $display("test shutdown done");
    complete_run();
  end
endmodule
